/* File: pkg/cars_cfg.svh */
// Register offsets, field positions and reset values of the measurement readback bank.
`ifndef CARS_CFG_SVH
`define CARS_CFG_SVH
`define CARS_OFF_BATTERY_VOLTAGE_CODE     8'h0e
`define CARS_OFF_SYSTEM_VOLTAGE_CODE     8'h0f
`define CARS_OFF_TS       8'h10
`define CARS_OFF_VBUS     8'h11
`define CARS_OFF_ICHG     8'h12
`define CARS_OFF_STAT     8'h13
`define CARS_OFF_INT_STAT 8'h20
`define CARS_OFF_INT_MASK 8'h21
`define CARS_OFF_CTRL     8'h22
`define CARS_FLAG_POS     7
`define CARS_IREG_POS     6
`define CARS_CODE_RST     7'h00
`define CARS_ILIM_RST     6'h00
`define CARS_REG_RST      8'h00
`define CARS_INT_W        5
`define CARS_CTRL_RST     8'h00
`endif

/* File: pkg/cars_pkg.sv */
// Types shared by the readback bank.
package cars_pkg;
  typedef struct packed {
    logic       thermal_regulation_flag;
    logic [6:0] battery_voltage_code;
    logic [6:0] system_voltage_code;
    logic [6:0] thermistor_ratio_code;
    logic       input_attached_flag;
    logic [6:0] input_bus_voltage_code;
    logic [6:0] charge_current_code;
    logic       battery_short;
    logic       input_voltage_regulation_flag;
    logic       input_current_regulation_flag;
    logic       optimizer_enabled;
    logic [5:0] optimizer_current_limit;
  } cars_meas_t;

  typedef enum logic [1:0] {
    CARS_IDLE,
    CARS_READ,
    CARS_WRITE
  } cars_phase_t;
endpackage

/* File: rtl/cars_edge.sv */
// Rising-edge detector for a set of status levels.
`timescale 1ns/100ps
module cars_edge #(
  parameter int W = 5
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] level,
  output logic      [W-1:0] rise
);
  logic [W-1:0] level_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      level_q <= '0;
    end else begin
      level_q <= level;
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_rise
      assign rise[i] = level[i] & ~level_q[i];
    end
  endgenerate
endmodule

/* File: rtl/cars_top.sv */
// Measurement and status readback bank of the charger, reached over AHB-Lite.
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/100ps
`include "cars_cfg.svh"
module cars_top (
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire cars_pkg::cars_meas_t meas,
  output logic                    irq
);
  cars_pkg::cars_meas_t snap;
  cars_pkg::cars_phase_t phase;
  logic [7:0]             addr_q;
  logic [`CARS_INT_W-1:0] int_stat;
  logic [`CARS_INT_W-1:0] int_mask;
  logic [7:0]             ctrl;
  logic [`CARS_INT_W-1:0] ev_level;
  logic [`CARS_INT_W-1:0] ev_rise;
  logic                   take;
  logic [7:0]             next_rdata;
  logic [7:0]             ichg_byte;
  logic [7:0]             stat_byte;

  // Word index of a byte address.
  function automatic logic [7:0] word_index(input logic [31:0] a);
    return a[9:2];
  endfunction

  // Measurements are sampled each cycle; a frozen snapshot is kept while ctrl bit 0 is set.
  always_ff @(posedge mclk) begin
    if (rst) begin
      snap <= '0;
    end else if (!ctrl[0]) begin
      snap <= meas;
    end
  end

  assign ichg_byte = {1'b0, snap.battery_short ? `CARS_CODE_RST : snap.charge_current_code};
  assign stat_byte = {snap.input_voltage_regulation_flag, snap.input_current_regulation_flag,
                      snap.optimizer_enabled ? snap.optimizer_current_limit : `CARS_ILIM_RST};

  always_comb begin
    case (addr_q)
      `CARS_OFF_BATTERY_VOLTAGE_CODE:     next_rdata = {snap.thermal_regulation_flag, snap.battery_voltage_code};
      `CARS_OFF_SYSTEM_VOLTAGE_CODE:     next_rdata = {1'b0, snap.system_voltage_code};
      `CARS_OFF_TS:       next_rdata = {1'b0, snap.thermistor_ratio_code};
      `CARS_OFF_VBUS:     next_rdata = {snap.input_attached_flag, snap.input_bus_voltage_code};
      `CARS_OFF_ICHG:     next_rdata = ichg_byte;
      `CARS_OFF_STAT:     next_rdata = stat_byte;
      `CARS_OFF_INT_STAT: next_rdata = {3'h0, int_stat};
      `CARS_OFF_INT_MASK: next_rdata = {3'h0, int_mask};
      `CARS_OFF_CTRL:     next_rdata = ctrl;
      default:            next_rdata = 8'h00;
    endcase
  end

  assign take = hsel & hready & htrans[1];

  always_ff @(posedge mclk) begin
    if (rst) begin
      phase  <= cars_pkg::CARS_IDLE;
      addr_q <= 8'h00;
    end else if (take) begin
      phase  <= hwrite ? cars_pkg::CARS_WRITE : cars_pkg::CARS_READ;
      addr_q <= word_index(haddr);
    end else if (hready) begin
      phase  <= cars_pkg::CARS_IDLE;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Read data is driven in the data phase from the captured index.
  always_comb begin
    case (phase)
      cars_pkg::CARS_READ: hrdata = {24'h000000, next_rdata};
      default:             hrdata = 32'h00000000;
    endcase
  end

  // Mask and control are written here and interrupt status is write-one-clear below; measurement addresses ignore writes.
  always_ff @(posedge mclk) begin
    if (rst) begin
      int_mask <= '0;
      ctrl     <= `CARS_CTRL_RST;
    end else if (phase == cars_pkg::CARS_WRITE) begin
      case (addr_q)
        `CARS_OFF_INT_MASK: int_mask <= hwdata[`CARS_INT_W-1:0];
        `CARS_OFF_CTRL:     ctrl     <= hwdata[7:0];
        default:            ctrl     <= ctrl;
      endcase
    end
  end

  assign ev_level = {snap.battery_short, snap.input_current_regulation_flag,
                     snap.input_voltage_regulation_flag, snap.input_attached_flag,
                     snap.thermal_regulation_flag};

  cars_edge #(
    .W(`CARS_INT_W)
  ) u_edge (
    .mclk  (mclk),
    .rst   (rst),
    .level (ev_level),
    .rise  (ev_rise)
  );

  // Set wins over a write-one clear in the same cycle.
  always_ff @(posedge mclk) begin
    if (rst) begin
      int_stat <= '0;
    end else if (phase == cars_pkg::CARS_WRITE && addr_q == `CARS_OFF_INT_STAT) begin
      int_stat <= (int_stat & ~hwdata[`CARS_INT_W-1:0]) | ev_rise;
    end else begin
      int_stat <= int_stat | ev_rise;
    end
  end

  assign irq = |(int_stat & int_mask);
endmodule

/* File: sim/cars_props.sv */
// Checker of the readback bank ports.
`timescale 1ns/100ps
module cars_props (
  input wire logic                 mclk,
  input wire logic                 rst,
  input wire logic                 hsel,
  input wire logic [31:0]          haddr,
  input wire logic [1:0]           htrans,
  input wire logic                 hwrite,
  input wire logic [31:0]          hwdata,
  input wire logic                 hready,
  input wire logic [31:0]          hrdata,
  input wire logic                 hreadyout,
  input wire logic                 hresp,
  input wire cars_pkg::cars_meas_t meas
);
  logic                 go;
  logic                 wr_ctrl;
  logic                 frozen;
  cars_pkg::cars_meas_t m;
  assign go = hsel && hready && htrans[1];
  // Mirror of the snapshot: a one written to control bit 0 freezes it from the cycle after the data phase.
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_ctrl <= 1'b0;
      frozen  <= 1'b0;
      m       <= '0;
    end else begin
      wr_ctrl <= go && hwrite && haddr[9:0] == 10'h088;
      if (wr_ctrl) begin
        frozen <= hwdata[0];
      end
      if (!frozen) begin
        m <= meas;
      end
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_batt_read: assert property (go && !hwrite && haddr[7:0] == 8'h38
    |=> hrdata == {24'h0, m.thermal_regulation_flag, m.battery_voltage_code}) else $error("battery read");
  a_sys_read: assert property (go && !hwrite && haddr[7:0] == 8'h3c
    |=> hrdata == {25'h0, m.system_voltage_code}) else $error("system read");
  a_therm_read: assert property (go && !hwrite && haddr[7:0] == 8'h40
    |=> hrdata == {25'h0, m.thermistor_ratio_code}) else $error("thermistor read");
  a_bus_read: assert property (go && !hwrite && haddr[7:0] == 8'h44
    |=> hrdata == {24'h0, m.input_attached_flag, m.input_bus_voltage_code}) else $error("bus read");
  a_curr_read: assert property (go && !hwrite && haddr[7:0] == 8'h48
    |=> hrdata == (m.battery_short ? 32'h0 : {25'h0, m.charge_current_code})) else $error("current read");
  a_stat_read: assert property (go && !hwrite && haddr[7:0] == 8'h4c
    |=> hrdata == {24'h0, m.input_voltage_regulation_flag, m.input_current_regulation_flag,
    (m.optimizer_enabled ? m.optimizer_current_limit : 6'h00)}) else $error("status read");
  a_write_quiet: assert property (go && hwrite |=> hrdata == 32'h0) else $error("write data phase");
  a_okay_resp: assert property (hreadyout && !hresp) else $error("response");
endmodule
bind cars_top cars_props cars_props_i (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
  .hreadyout, .hresp, .meas);

/* File: sim/tb.sv */
// Self-checking bench of the readback bank.
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
  $display("CHECK FAILED %0t got %h expected %h", $time, (a), (b)); end end
module tb;
  logic                 mclk = 1'b0;
  logic                 rst = 1'b1;
  logic                 hsel = 1'b0;
  logic [31:0]          haddr = 32'h0;
  logic [1:0]           htrans = 2'h0;
  logic                 hwrite = 1'b0;
  logic [31:0]          hwdata = 32'h0;
  logic [31:0]          hrdata;
  logic                 hreadyout;
  logic                 hresp;
  logic                 irq;
  cars_pkg::cars_meas_t meas = '0;
  logic [63:0]          seed = 64'h5e;
  logic [31:0]          rdata;
  int                   err_count = 0;
  int                   comparisons = 0;
  always #25 mclk = ~mclk;
  cars_top cars_top_i (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .meas, .irq);
  function automatic logic [63:0] lfsr(input logic [63:0] s);
    return {s[62:0], s[63] ^ s[62] ^ s[60] ^ s[59]};
  endfunction
  function automatic int model(input cars_pkg::cars_meas_t m, input int i);
    case (i)
      0: return m.thermal_regulation_flag * 128 + m.battery_voltage_code;
      1: return m.system_voltage_code;
      2: return m.thermistor_ratio_code;
      3: return m.input_attached_flag * 128 + m.input_bus_voltage_code;
      4: return m.battery_short ? 0 : m.charge_current_code;
      default: return m.input_voltage_regulation_flag * 128 + m.input_current_regulation_flag * 64 +
        (m.optimizer_enabled ? m.optimizer_current_limit : 0);
    endcase
  endfunction
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rdata = hrdata;
    repeat (2) @(posedge mclk);
  endtask
  task automatic complete_run;
    $display("err_count %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    `CHK({hrdata, irq}, 33'h0)
    for (int n = 0; n < 40; n++) begin
      seed = lfsr(seed);
      meas <= seed[46:0];
      for (int i = 0; i < 6; i++) begin
        bus(n[0], 8'h38 + 8'(4 * i), seed[63:32]);
        bus(1'b0, 8'h38 + 8'(4 * i), 32'h0);
        `CHK(rdata, 32'(model(meas, i)))
      end
    end
    meas <= '0;
    bus(1'b1, 8'h80, 32'h1f);
    bus(1'b1, 8'h84, 32'h1f);
    `CHK(irq, 1'b0)
    meas.thermal_regulation_flag <= 1'b1;
    bus(1'b0, 8'h80, 32'h0);
    `CHK({rdata, irq}, 33'h3)
    bus(1'b1, 8'h84, 32'h0);
    `CHK(irq, 1'b0)
    bus(1'b1, 8'h84, 32'h1f);
    bus(1'b1, 8'h80, 32'h1);
    bus(1'b0, 8'h60, 32'h0);
    `CHK({rdata, irq}, 33'h0)
    // A frozen snapshot must hide a later change of the battery code until it is released.
    bus(1'b1, 8'h88, 32'h1);
    meas.battery_voltage_code <= 7'h55;
    bus(1'b0, 8'h38, 32'h0);
    `CHK(rdata, 32'h00000080)
    bus(1'b1, 8'h88, 32'h0);
    bus(1'b0, 8'h38, 32'h0);
    `CHK(rdata, 32'(model(meas, 0)))
    complete_run();
  end
endmodule
